// [hw/xcsd_decoder.v]
// Purpose: lpc i/o cycle decode into chip selects and x-bus strobes
// Assumes: cycStart is a one-cycle pulse with address, direction, data
// Notes:   selects stay low for 11 of the 12 strobe window cycles
`timescale 1ns/10ps
`default_nettype none
`include "xcsd_regs.vh"
module xcsd_decoder (
   // clock and reset
   input  wire        clk,
   input  wire        nrst,
   // host cycle from lpc front end
   input  wire        cycStart,
   input  wire [15:0] cycAddr,
   input  wire        cycWrite,
   input  wire [7:0]  cycWdata,
   output wire        cycBusy,
   output reg         cycDone_r,
   output reg  [7:0]  cycRdata_r,
   // strap and pin mode
   input  wire        keyboard_enable_strap_n,
   input  wire        altFuncSel,
   input  wire        gpioModeSel,
   input  wire        watchdog_out,
   input  wire [7:0]  gpioP3Out,
   input  wire [7:0]  gpioP3Oe,
   output wire [7:0]  gpioP3In,
   output wire [7:0]  chip_enable_config_reg,
   // keyboard interrupts
   input  wire        kbd_irq_in_a,
   input  wire        kbd_irq_in_b,
   output reg         kbdIrq1_r,
   output reg         kbdIrq12_r,
   // chip selects and strobes
   output reg         post_code_select_n,
   output reg         rtc_select_n,
   output reg         kbd_ctrl_select_n,
   output reg         embedded_ctrl_select_n,
   output reg         ioReadN,
   output reg         ioWriteN,
   // x-bus data pins
   input  wire [7:0]  xbus_data_in,
   output wire [7:0]  xbus_data_out,
   output wire [7:0]  xbus_data_oe
);
   // decoded target of the cycle in flight
   localparam SEL_NONE = 3'd0;
   localparam SEL_POST = 3'd1;
   localparam SEL_RTC  = 3'd2;
   localparam SEL_KBD  = 3'd3;
   localparam SEL_EC   = 3'd4;

   reg  [7:0] cfg_r;
   reg        strapDone_r;
   reg  [2:0] sel_r;
   reg        wr_r;
   reg  [7:0] wdata_r;
   reg  [2:0] selNxt;
   wire       active;
   wire       lastCyc;

   wire       take;
   wire       startStrobe;
   wire       kbEnable;
   reg        postSelN_nxt;
   reg        rtcSelN_nxt;
   reg        kbdSelN_nxt;
   reg        ecSelN_nxt;
   reg        ioReadN_nxt;
   reg        ioWriteN_nxt;

   function [2:0] decodeSel;
      input [15:0] a;
      input        w;
      input        kbEn;
      begin
         decodeSel = SEL_NONE;
         if (w && a == `XCSD_ADDR_POST) begin
            decodeSel = SEL_POST;
         end
         if (a == `XCSD_ADDR_RTC0 || a == `XCSD_ADDR_RTC1) begin
            decodeSel = SEL_RTC;
         end
         if (kbEn && (a == `XCSD_ADDR_KBD0 || a == `XCSD_ADDR_KBD1)) begin
            decodeSel = SEL_KBD;
         end
         if (kbEn && (a == `XCSD_ADDR_EC0 || a == `XCSD_ADDR_EC1)) begin
            decodeSel = SEL_EC;
         end
      end
   endfunction

   // pins go low the cycle after an open window cycle that is not its final one
   function inWindow;
      input act;
      input last;
      input hit;
      begin
         inWindow = act && !last && hit;
      end
   endfunction

   assign chip_enable_config_reg = cfg_r;
   assign cycBusy = active;
   // a request while busy is dropped unanswered; the host waits for done
   assign take        = cycStart && !active;
   assign startStrobe = take && (selNxt != SEL_NONE);
   // keyboard decodes stay off until the strap has been caught
   assign kbEnable    = cfg_r[`XCSD_CFG_KBEN_BIT] & strapDone_r;

   // strap caught on the first edge after release; constant under reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r       <= `XCSD_CFG_RESET;
         strapDone_r <= 1'b0;
      end else if (!strapDone_r) begin
         cfg_r[`XCSD_CFG_KBEN_BIT] <= ~keyboard_enable_strap_n;
         strapDone_r               <= 1'b1;
      end
   end

   always @* begin
      selNxt = decodeSel(cycAddr, cycWrite, kbEnable);
   end

   xcsd_strobe uStrobe (
      .clk      (clk),
      .nrst     (nrst),
      .start    (startStrobe),
      .active_r (active),
      .lastCyc  (lastCyc)
   );

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_r      <= SEL_NONE;
         wr_r       <= 1'b0;
         wdata_r    <= 8'h00;
         cycDone_r  <= 1'b0;
         cycRdata_r <= 8'h00;
      end else begin
         cycDone_r <= 1'b0;
         if (take) begin
            sel_r   <= selNxt;
            wr_r    <= cycWrite;
            wdata_r <= cycWdata;
            // unmapped cycles finish at once and read as ff
            if (selNxt == SEL_NONE) begin
               cycDone_r  <= 1'b1;
               cycRdata_r <= 8'hff;
            end
         end else if (lastCyc) begin
            cycDone_r <= 1'b1;
            // sample slave data at strobe end
            if (!wr_r) begin
               cycRdata_r <= xbus_data_in;
            end
         end
      end
   end

   // next select and strobe levels
   always @* begin
      postSelN_nxt = ~inWindow(active, lastCyc, sel_r == SEL_POST);
      kbdSelN_nxt  = ~inWindow(active, lastCyc, sel_r == SEL_KBD);
      ecSelN_nxt   = ~inWindow(active, lastCyc, sel_r == SEL_EC);
      if (altFuncSel) begin
         rtcSelN_nxt = watchdog_out;
      end else begin
         rtcSelN_nxt = ~inWindow(active, lastCyc, sel_r == SEL_RTC);
      end
      ioReadN_nxt  = ~inWindow(active, lastCyc, !wr_r);
      ioWriteN_nxt = ~inWindow(active, lastCyc, wr_r);
   end

   // selects and strobes are registered so they stay glitch free
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         post_code_select_n     <= 1'b1;
         rtc_select_n           <= 1'b1;
         kbd_ctrl_select_n      <= 1'b1;
         embedded_ctrl_select_n <= 1'b1;
         ioReadN                <= 1'b1;
         ioWriteN               <= 1'b1;
      end else begin
         post_code_select_n     <= postSelN_nxt;
         rtc_select_n           <= rtcSelN_nxt;
         kbd_ctrl_select_n      <= kbdSelN_nxt;
         embedded_ctrl_select_n <= ecSelN_nxt;
         ioReadN                <= ioReadN_nxt;
         ioWriteN               <= ioWriteN_nxt;
      end
   end

   // write data is held from take to the end of the strobe
   // shared bidirectional path
   // gpio port 3 takes the pins
   assign xbus_data_out = gpioModeSel ? gpioP3Out : wdata_r;
   assign xbus_data_oe  = gpioModeSel ? gpioP3Oe : {8{active && wr_r}};
   assign gpioP3In      = xbus_data_in;

   // the strap gate also masks the irq outputs
   // keyboard irq inputs registered
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         kbdIrq1_r  <= 1'b0;
         kbdIrq12_r <= 1'b0;
      end else begin
         kbdIrq1_r  <= kbd_irq_in_a & cfg_r[`XCSD_CFG_KBEN_BIT];
         kbdIrq12_r <= kbd_irq_in_b & cfg_r[`XCSD_CFG_KBEN_BIT];
      end
   end
endmodule // xcsd_decoder
`default_nettype wire

// [hw/xcsd_regs.vh]
// Purpose: constants for the x-bus chip select decoder
// Assumes: host cycles arrive already decoded from the lpc port
// Notes:   all decodes are 16-bit i/o addresses
//
// Functional notes
// - post select on i/o write 0x80
// - rtc select on 0x70 or 0x71
// - keyboard select on 0x60 and 0x64
// - embedded select on 0x62 and 0x66
// - keyboard decodes only when strap low
// - strap sampled into config bit 7
// - accept keyboard irq 1 and 12 inputs
// - read strobe, slave drives data bus
// - write strobe, device drives data bus
// - bidirectional 8-bit x-bus data path
// - alternate function puts watchdog on rtc pin
// - gpio mode turns data bus into port 3
`ifndef XCSD_REGS_VH
`define XCSD_REGS_VH
`define XCSD_ADDR_POST     16'h0080
`define XCSD_ADDR_RTC0     16'h0070
`define XCSD_ADDR_RTC1     16'h0071
`define XCSD_ADDR_KBD0     16'h0060
`define XCSD_ADDR_KBD1     16'h0064
`define XCSD_ADDR_EC0      16'h0062
`define XCSD_ADDR_EC1      16'h0066
`define XCSD_CFG_KBEN_BIT  7
`define XCSD_CFG_RESET     8'h00
`define XCSD_STROBE_CYC    8'h0c
`endif

// [hw/xcsd_strobe.v]
// Purpose: timed x-bus strobe sequencer
// Assumes: one request at a time
// Notes:   strobe width fixed by header count
`timescale 1ns/10ps
`default_nettype none
`include "xcsd_regs.vh"
module xcsd_strobe (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // request
   input  wire       start,
   // strobe state
   output reg        active_r,
   output wire       lastCyc
);
   reg [7:0] cnt_r;
   assign lastCyc = active_r && (cnt_r == 8'h01);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_r <= 1'b0;
         cnt_r    <= 8'h00;
      end else if (start && !active_r) begin
         active_r <= 1'b1;
         cnt_r    <= `XCSD_STROBE_CYC;
      end else if (active_r) begin
         cnt_r    <= cnt_r - 8'h01;
         if (cnt_r == 8'h01) begin
            active_r <= 1'b0;
         end
      end
   end
endmodule // xcsd_strobe
`default_nettype wire

// [test/xcsd_props.sv]
// Purpose: port timing checks for the decoder
// Assumes: one clock, async active-low reset
// Notes:   selects low from cycle 2 to 12
`timescale 1ns/10ps
`default_nettype none
module xcsd_props (
   // host side
   input wire logic        clk, nrst, cycStart, cycWrite, cycBusy, cycDone_r,
   input wire logic [15:0] cycAddr,
   // modes, strap, irq
   input wire logic        altFuncSel, gpioModeSel, kbd_irq_in_a, kbdIrq1_r,
   input wire logic [7:0]  chip_enable_config_reg, xbus_data_oe,
   // selects and strobes
   input wire logic        post_code_select_n, rtc_select_n, kbd_ctrl_select_n,
   input wire logic        embedded_ctrl_select_n, ioReadN, ioWriteN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // pin modes excluded: they reroute the pins
   wire logic take = cycStart && !cycBusy && !gpioModeSel && !altFuncSel;
   wire logic kbEn = chip_enable_config_reg[7];
   wire logic post = take && cycWrite && cycAddr == 16'h0080;
   post_sel_a: assert property (post |-> ##2 !post_code_select_n)
      else $error("post select missing");
   rtc_sel_a: assert property (take && cycAddr[15:1] == 15'h0038 |-> ##2 !rtc_select_n)
      else $error("rtc select missing");
   kbd_sel_a: assert property (take && kbEn && (cycAddr == 16'h0060 || cycAddr == 16'h0064)
      |-> ##2 !kbd_ctrl_select_n) else $error("kbd select missing");
   ec_sel_a: assert property (take && kbEn && (cycAddr == 16'h0062 || cycAddr == 16'h0066)
      |-> ##2 !embedded_ctrl_select_n) else $error("ec select missing");
   kb_gate_a: assert property (!kbEn |-> kbd_ctrl_select_n && embedded_ctrl_select_n)
      else $error("kbd select while disabled");
   wr_drive_a: assert property (post |=> xbus_data_oe == 8'hff ##1 !ioWriteN && ioReadN)
      else $error("write drive wrong");
   rd_release_a: assert property ($fell(ioReadN) |-> xbus_data_oe == 8'h00 && ioWriteN)
      else $error("bus driven on read");
   strobe_len_a: assert property ($fell(ioWriteN) |-> !ioWriteN [*8] ##3 !ioWriteN
      ##1 ioWriteN && cycDone_r) else $error("strobe width wrong");
   sel_idle_a: assert property (!cycBusy && !altFuncSel |-> post_code_select_n && rtc_select_n
      && kbd_ctrl_select_n && embedded_ctrl_select_n) else $error("select outside cycle");
   irq_pass_a: assert property (kbEn && $past(kbEn) |-> kbdIrq1_r == $past(kbd_irq_in_a))
      else $error("irq not passed");
endmodule // xcsd_props
`default_nettype wire

// [test/xcsd_xbus_slave.sv]
// Purpose: x-bus slave model
// Assumes: one slave answers every strobe
// Notes:   released bus toggles so stale data is never seen
`timescale 1ns/10ps
`default_nettype none
module xcsd_xbus_slave (
   // strobes and wire level
   input  wire logic       clk, ioReadN, ioWriteN,
   input  wire logic [7:0] wireIn, rdByte,
   // slave drive and latch
   output var  logic [7:0] busIn, wrByte
);
   initial busIn = 8'h3c;
   always @(posedge clk) begin
      busIn <= !ioReadN ? rdByte : ~busIn;
      if (!ioWriteN) wrByte <= wireIn;
   end
endmodule // xcsd_xbus_slave
`default_nettype wire

// [test/xcsd_decoder_bench.sv]
// Purpose: self-checking bench for the decoder
// Assumes: slave answers reads with inverted address
// Notes:   inputs change by nba on rising edge
`timescale 1ns/10ps
`default_nettype none
module xcsd_decoder_bench;
   logic clk = 1'b0, nrst = 1'b0, cycStart = 1'b0, cycWrite = 1'b0, watchdog_out = 1'b0;
   logic keyboard_enable_strap_n = 1'b0, altFuncSel = 1'b0, gpioModeSel = 1'b0;
   logic kbd_irq_in_a = 1'b0, kbd_irq_in_b = 1'b0;
   logic [15:0] cycAddr = 16'h0000;
   logic [7:0] cycWdata = 8'h00, gpioP3Out = 8'h00, gpioP3Oe = 8'h00;
   logic [15:0] tbl [6] = '{16'h0070, 16'h0071, 16'h0060, 16'h0064, 16'h0062, 16'h0066};
   wire logic cycBusy, cycDone_r, kbdIrq1_r, kbdIrq12_r, post_code_select_n, rtc_select_n;
   wire logic kbd_ctrl_select_n, embedded_ctrl_select_n, ioReadN, ioWriteN;
   wire logic [7:0] cycRdata_r, gpioP3In, chip_enable_config_reg, xbus_data_out, xbus_data_oe;
   wire logic [7:0] xbus_data_in, slvBus, slvWr;
   int n_fail = 0, cmp_count = 0;
   always #5 clk = ~clk;
   assign xbus_data_in = (xbus_data_oe & xbus_data_out) | (~xbus_data_oe & slvBus);
   xcsd_decoder dut (.clk, .nrst, .cycStart, .cycAddr, .cycWrite, .cycWdata, .cycBusy,
      .cycDone_r, .cycRdata_r, .keyboard_enable_strap_n, .altFuncSel, .gpioModeSel,
      .watchdog_out, .gpioP3Out, .gpioP3Oe, .gpioP3In, .chip_enable_config_reg, .kbd_irq_in_a,
      .kbd_irq_in_b, .kbdIrq1_r, .kbdIrq12_r, .post_code_select_n, .rtc_select_n,
      .kbd_ctrl_select_n, .embedded_ctrl_select_n, .ioReadN, .ioWriteN, .xbus_data_in,
      .xbus_data_out, .xbus_data_oe);
   xcsd_xbus_slave slv (.clk, .ioReadN, .ioWriteN, .wireIn(xbus_data_in),
      .rdByte(~cycAddr[7:0]), .busIn(slvBus), .wrByte(slvWr));
   task chk(input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task rst(input logic s);
      @(posedge clk);
      nrst <= 1'b0;
      keyboard_enable_strap_n <= s;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   // latency counted from the take edge; a hang ends the run
   task cyc(input logic [15:0] a, input logic w, input logic [7:0] d, lat, rd);
      int n;
      @(posedge clk);
      {cycAddr, cycWrite, cycWdata, cycStart} <= {a, w, d, 1'b1};
      @(posedge clk);
      cycStart <= 1'b0;
      for (n = 0; n < 40 && cycDone_r !== 1'b1; n++) @(posedge clk);
      if (n == 40) begin
         n_fail++;
         finish_test;
      end else begin
         chk(n[7:0], lat);
         if (!w) chk(cycRdata_r, rd);
      end
   endtask
   task t_map;
      rst(1'b0);
      chk(chip_enable_config_reg, 8'h80);
      cyc(16'h0080, 1'b1, 8'h55, 8'd13, 8'h00);
      chk(slvWr, 8'h55);
      cyc(16'h0080, 1'b0, 8'h00, 8'd1, 8'hff);
      cyc(16'h0064, 1'b1, 8'ha3, 8'd13, 8'h00);
      chk(slvWr, 8'ha3);
      for (int i = 0; i < 6; i++) cyc(tbl[i], 1'b0, 8'h00, 8'd13, ~tbl[i][7:0]);
   endtask
   task t_irq;
      {kbd_irq_in_a, kbd_irq_in_b} <= 2'b10;
      repeat (2) @(posedge clk);
      chk({6'h00, kbdIrq1_r, kbdIrq12_r}, 8'h02);
      {kbd_irq_in_a, kbd_irq_in_b} <= 2'b01;
      repeat (2) @(posedge clk);
      chk({6'h00, kbdIrq1_r, kbdIrq12_r}, 8'h01);
   endtask
   task t_strap;
      rst(1'b1);
      chk(chip_enable_config_reg, 8'h00);
      cyc(16'h0062, 1'b0, 8'h00, 8'd1, 8'hff);
      chk({6'h00, kbdIrq1_r, kbdIrq12_r}, 8'h00);
   endtask
   task t_pins;
      altFuncSel <= 1'b1;
      // ends with watchdog high so the select is idle when the mode drops
      for (int v = 1; v < 4; v++) begin
         watchdog_out <= v[0];
         repeat (2) @(posedge clk);
         chk({7'h00, rtc_select_n}, {7'h00, v[0]});
      end
      {altFuncSel, gpioModeSel, gpioP3Out, gpioP3Oe} <= {2'b01, 8'ha5, 8'hf0};
      repeat (2) @(posedge clk);
      chk(xbus_data_oe, 8'hf0);
      chk(xbus_data_out, 8'ha5);
      chk({4'h0, gpioP3In[7:4]}, 8'h0a);
   endtask
   initial begin
      t_map;
      t_irq;
      t_strap;
      t_pins;
      finish_test;
   end
endmodule // xcsd_decoder_bench
bind xcsd_decoder xcsd_props chkr (.*);
`default_nettype wire
